//--- logic/som_pkg.sv
/*
  Shared constants of the sysref output and mute path: register
  indices, fields, reset values and encodings.
  Assumes one clock domain and an indexed register port.
*/
package som_pkg;
  // Register indices (address port carries the index)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_INT_STAT = 8'h02;
  localparam logic [7:0] ADDR_INT_MASK = 8'h03;
  localparam logic [7:0] ADDR_MUTE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h05;
  localparam logic [7:0] ADDR_SR_REQ_CTRL = 8'h1A;
  localparam logic [7:0] ADDR_CH_CFG = 8'h10;
  localparam logic [7:0] ADDR_CH_SRDIV = 8'h20;
  localparam logic [7:0] ADDR_CH_DLY = 8'h30;
  // Control register bits
  localparam int CTRL_SOFT_RST = 0;
  localparam int CTRL_APLL_AUTO = 1;
  // sysref_request_control fields
  localparam int REQ_MODE_LSB = 4;
  localparam int REQ_SEL_LSB = 2;
  localparam int REQ_CNT_LSB = 0;
  localparam logic [1:0] REQ_MODE_CONT = 2'h0;
  localparam logic [1:0] REQ_MODE_RESAMPLE = 2'h3;
  // Channel config fields
  localparam int CFG_CHDIV_LSB = 0;
  localparam int CFG_SR_SEL = 12;
  localparam int CFG_PULSE = 13;
  localparam int CFG_MUTE_EN = 14;
  localparam int CFG_DRV_LSB = 15;
  localparam int CFG_SRC_LSB = 17;
  localparam int CFG_REP_EN = 19;
  localparam int CFG_REP_PIN = 20;
  localparam int CFG_POLA_LSB = 21;
  localparam int CFG_POLB_LSB = 23;
  // Delay register fields
  localparam int DLY_STATIC_LSB = 0;
  localparam int DLY_SR_LSB = 8;
  localparam int DLY_ANA_LSB = 12;
  // Single-ended output states
  localparam logic [1:0] POL_NORMAL = 2'h0;
  localparam logic [1:0] POL_INVERT = 2'h1;
  localparam logic [1:0] POL_HIZ = 2'h2;
  // Reset values
  localparam logic [31:0] CH_CFG_RST = 32'h0001_8004;
  localparam logic [31:0] CH_SRDIV_RST = 32'h0000_0004;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] MUTE_CTRL_RST = 32'h0000_0007;
  // Sysref frequency ceiling
  localparam int SR_MAX_HZ = 25000000;
endpackage

//--- logic/som_chan.sv
/*
  One output channel: channel divider, cascaded sysref divider,
  static start delay, sysref delay line and pulser.
  Assumes i_tick is a one-cycle pulse per source clock period.
*/
`timescale 1ns/10ps
module som_chan #(
  parameter int CD_W = 12,
  parameter int SR_W = 20,
  parameter int DLY_W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Source and run control
  input wire logic i_tick,
  input wire logic i_run,
  // Configuration
  input wire logic [CD_W-1:0] i_chdiv,
  input wire logic i_sr_sel,
  input wire logic [SR_W-1:0] i_srdiv,
  input wire logic [DLY_W-1:0] i_static_dly,
  input wire logic [3:0] i_sr_dly,
  input wire logic i_pulse_mode,
  input wire logic i_pulse_go,
  input wire logic [3:0] i_pulse_cnt,
  // Outputs
  output logic o_clk,
  output logic o_replica,
  output logic o_sr_rise
);
  logic [DLY_W-1:0] hold_q;
  logic [CD_W-1:0] cd_q;
  logic [SR_W-1:0] sr_q;
  logic [14:0] line_q;
  logic [3:0] left_q;
  logic pass_q, dly_prev_q, sr_prev_q;
  logic [CD_W-1:0] cd_n;
  logic [SR_W-1:0] sr_n;
  logic cd_clk, sr_clk, cd_wrap, dly, rise, pass_now;
  logic [15:0] taps;

  // Dividers below 2 behave as 2 so the output still toggles
  assign cd_n = (i_chdiv < CD_W'(2)) ? CD_W'(2) : i_chdiv;
  assign sr_n = (i_srdiv < SR_W'(2)) ? SR_W'(2) : i_srdiv;
  assign cd_clk = cd_q < (cd_n >> 1);
  assign sr_clk = sr_q < (sr_n >> 1);
  assign cd_wrap = i_tick && hold_q == '0 && cd_q >= cd_n - CD_W'(1);
  assign taps = {line_q, sr_clk};
  assign dly = taps[i_sr_dly];
  assign rise = i_tick && dly && !dly_prev_q;
  assign pass_now = rise ? (left_q != 4'h0) : pass_q;

  ////////////////////////////////////////////////////////////////////////
  // Static delay holds the dividers off; both counters restart together
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || !i_run)
    begin
      hold_q <= i_rst_n ? i_static_dly : '0; // (RL9)
      cd_q <= '0;
      sr_q <= '0;
    end
    else if (i_tick)
    begin
      if (hold_q != '0)
        hold_q <= hold_q - DLY_W'(1);
      else
      begin
        // Wrap at or above the end so a smaller divide value never runs away
        cd_q <= (cd_q >= cd_n - CD_W'(1)) ? '0 : cd_q + CD_W'(1);
        if (cd_wrap) // (RL2)
          sr_q <= (sr_q >= sr_n - SR_W'(1)) ? '0 : sr_q + SR_W'(1);
      end
    end
  end

  // Sysref digital delay line, one step per source period
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      line_q <= '0;
    else if (i_tick)
      line_q <= {line_q[13:0], sr_clk}; // (RL9)
  end

  // Pulser: a request grants a fixed number of whole periods
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      left_q <= 4'h0;
      pass_q <= 1'b0;
      dly_prev_q <= 1'b0;
    end
    else
    begin
      if (i_tick)
        dly_prev_q <= dly;
      pass_q <= pass_now;
      if (i_pulse_go)
        left_q <= i_pulse_cnt;
      else if (rise && left_q != 4'h0)
        left_q <= left_q - 4'h1;
    end
  end

  // Registered outputs; replica taps the undelayed sysref clock
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_clk <= 1'b0;
      o_replica <= 1'b0;
      o_sr_rise <= 1'b0;
      sr_prev_q <= 1'b0;
    end
    else
    begin
      sr_prev_q <= sr_clk;
      o_sr_rise <= sr_clk && !sr_prev_q;
      o_replica <= i_sr_sel && sr_clk; // (RL7) (RL8)
      if (!i_sr_sel)
        o_clk <= cd_clk;
      else
        o_clk <= i_pulse_mode ? (dly && pass_now) : dly;
    end
  end
endmodule

//--- logic/som_mute.sv
/*
  Mute gate for one channel clock. Mute changes only while the clock
  is low, so no pulse is ever shortened.
  Assumes i_lvl is a registered clock level on the same clock.
*/
`timescale 1ns/10ps
module som_mute (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Clock level and mute request
  input wire logic i_lvl,
  input wire logic i_mute,
  // Gated clock and mute state
  output logic o_clk,
  output logic o_muted
);
  logic m_next;

  // Hold the previous decision while the clock is high
  assign m_next = i_lvl ? o_muted : i_mute; // (RL16)

  ////////////////////////////////////////////////////////////////////////
  // Gate and state register; starts muted so start-up is clean
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_muted <= 1'b1;
      o_clk <= 1'b0;
    end
    else
    begin
      o_muted <= m_next;
      o_clk <= i_lvl && !m_next; // (RL12) (RL14)
    end
  end
endmodule

//--- logic/som_top.sv
/*
  Output clock path: dividers, delays, sysref requests,
  pin replicas, output states, glitchless start-up and
  mute on loss of lock.
  Assumes ticks come from logic on i_clk; lock and request
  inputs are asynchronous and synchronised here.
*/
// The strobed register port is this design's own decision.
//
// Summary of operation
// (RL1) Sysref path spans one pulse-per-second to 25MHz
// (RL2) Sysref divider cascades after all but channels 2,3
// (RL3) Host selects resampled requests when aligning sysrefs
// (RL4) Host matches sample source to replica source
// (RL5) Pin replica needs pin enable and active source
// (RL6) Lowest enabled replica source feeds the pin
// (RL7) Replica taken after static delay, before others
// (RL8) Replica is always a continuous clock
// (RL9) Static delay per channel; sysref adds more delay
// (RL10) First two channels: normal, inverted, hi-z, low
// (RL11) Auto-mute starts outputs only after analog lock
// (RL12) Per-channel mute silences clock on invalid source
// (RL13) Invalid source chosen by per-loop lock mute bits
// (RL14) Mute disabled passes clock ungated
// (RL15) Divider powers down when both drivers disabled
// (RL16) Mute switches only while the clock is low
`timescale 1ns/10ps
module som_top #(
  parameter int NCH = 9,
  parameter int NPLL = 3,
  parameter int CD_W = 12,
  parameter int SR_W = 20
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Sources and lock status
  input wire logic [NPLL-1:0] i_src_tick,
  input wire logic [NPLL-1:0] i_apll_lock,
  input wire logic [NPLL-1:0] i_dpll_lock,
  input wire logic [NPLL-1:0] i_dpll_phlock,
  input wire logic i_sysref_req,
  // Output drivers, two per channel
  output logic [2*NCH-1:0] o_drv,
  output logic [2*NCH-1:0] o_drv_oe,
  output logic [4*NCH-1:0] o_analog_dly,
  // General-purpose pins
  output logic [1:0] o_pin,
  output logic [1:0] o_pin_oe,
  // Interrupt
  output logic o_irq
);
  localparam int NSYN = 3 * NPLL + 1;
  localparam int NEV = 2 * NPLL + 1;

  // Channels 2 and 3 have no sysref divider
  localparam logic [8:0] HAS_SR = 9'h1F3;

  generate
    if (NCH != 9 || NPLL != 3 || CD_W != 12 || SR_W != 20)
    begin : g_chk
      $error("som_top: unsupported channel layout");
    end
  endgenerate

  logic [31:0] ctrl_q, int_stat_q, int_mask_q, mute_ctrl_q, pin_ctrl_q;
  logic [7:0] req_ctrl_q;
  logic [31:0] cfg_q [NCH];
  logic [31:0] srdiv_q [NCH];
  logic [31:0] dly_q [NCH];
  logic [31:0] rdata_d;
  logic soft_rst_q;
  logic [NSYN-1:0] s1_q, s2_q, s3_q, filt_q, filt_prev_q;
  logic [NPLL-1:0] alock, dlock, phlock;
  logic req_lvl, req_rise;
  logic [NCH-1:0] chan_clk, rep, sr_rise, gclk, muted, started_q, mute_req;
  logic [NCH-1:0] run, go;
  logic [NCH-1:0] muted_prev_q;
  logic [NPLL-1:0] invalid;
  logic [NEV-1:0] ev;
  logic pend_q;
  logic [1:0] req_mode;
  logic [3:0] pulse_cnt;
  logic samp_rise;

  assign alock = filt_q[NPLL-1:0];
  assign dlock = filt_q[2*NPLL-1:NPLL];
  assign phlock = filt_q[3*NPLL-1:2*NPLL];
  assign req_lvl = filt_q[NSYN-1];
  assign req_rise = req_lvl && !filt_prev_q[NSYN-1];
  assign req_mode = req_ctrl_q[som_pkg::REQ_MODE_LSB+:2];
  assign pulse_cnt = 4'h1 << req_ctrl_q[som_pkg::REQ_CNT_LSB+:2];

  ////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; stages two and three must agree
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
      filt_prev_q <= '0;
    end
    else
    begin
      s1_q <= {i_sysref_req, i_dpll_phlock, i_dpll_lock, i_apll_lock};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_prev_q <= filt_q;
      for (int i = 0; i < NSYN; i++)
        if (s2_q[i] == s3_q[i])
          filt_q[i] <= s3_q[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source validity per loop from the selected lock conditions
  always_comb
  begin
    for (int p = 0; p < NPLL; p++)
      invalid[p] = (mute_ctrl_q[p] && !alock[p])
                || (mute_ctrl_q[NPLL+p] && !dlock[p])
                || (mute_ctrl_q[2*NPLL+p] && !phlock[p]); // (RL13)
  end

  // Resampled requests wait for the sample source's sysref edge
  always_comb
  begin
    case (req_ctrl_q[som_pkg::REQ_SEL_LSB+:2])
      2'h0: samp_rise = sr_rise[0];
      2'h1: samp_rise = sr_rise[1];
      2'h2: samp_rise = sr_rise[4];
      2'h3: samp_rise = sr_rise[5];
      default: samp_rise = 1'b0;
    endcase
  end

  // A request is pending until the resampling edge arrives
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      pend_q <= 1'b0;
    else if (req_mode != som_pkg::REQ_MODE_RESAMPLE)
      pend_q <= 1'b0;
    else if (req_rise)
      pend_q <= 1'b1;
    else if (samp_rise)
      pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Channels: start control, divider, mute gate
  generate
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
      logic [1:0] src;
      logic [1:0] drv_en;
      logic src_ok, tick, lock_ok;

      assign src = cfg_q[c][som_pkg::CFG_SRC_LSB+:2];
      assign drv_en = cfg_q[c][som_pkg::CFG_DRV_LSB+:2];
      assign src_ok = src < 2'(NPLL);
      assign tick = src_ok && i_src_tick[src];
      assign lock_ok = !ctrl_q[som_pkg::CTRL_APLL_AUTO] || (src_ok && alock[src]);
      assign run[c] = started_q[c] && drv_en != 2'h0 && !soft_rst_q; // (RL15)
      assign mute_req[c] = !started_q[c]
        || (cfg_q[c][som_pkg::CFG_MUTE_EN] && (!src_ok || invalid[src])); // (RL12)
      assign go[c] = (req_mode == som_pkg::REQ_MODE_RESAMPLE)
        ? (pend_q && samp_rise) : (req_mode != som_pkg::REQ_MODE_CONT && req_rise);

      // Start only after analog lock, and all channels on one source together
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n || soft_rst_q || drv_en == 2'h0)
          started_q[c] <= 1'b0;
        else if (lock_ok)
          started_q[c] <= 1'b1; // (RL11)
      end

      som_chan #(
        .CD_W(CD_W),
        .SR_W(SR_W),
        .DLY_W(8)
      ) u_chan (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_tick(tick),
        .i_run(run[c]),
        .i_chdiv(cfg_q[c][som_pkg::CFG_CHDIV_LSB+:CD_W]),
        .i_sr_sel(HAS_SR[c] && cfg_q[c][som_pkg::CFG_SR_SEL]), // (RL2)
        .i_srdiv(srdiv_q[c][SR_W-1:0]), // (RL1)
        .i_static_dly(dly_q[c][som_pkg::DLY_STATIC_LSB+:8]),
        .i_sr_dly(dly_q[c][som_pkg::DLY_SR_LSB+:4]),
        .i_pulse_mode(cfg_q[c][som_pkg::CFG_PULSE]),
        .i_pulse_go(go[c]),
        .i_pulse_cnt(pulse_cnt),
        .o_clk(chan_clk[c]),
        .o_replica(rep[c]),
        .o_sr_rise(sr_rise[c])
      );

      som_mute u_mute (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_lvl(chan_clk[c]),
        .i_mute(mute_req[c]),
        .o_clk(gclk[c]),
        .o_muted(muted[c])
      );

      assign o_analog_dly[4*c+:4] = dly_q[c][som_pkg::DLY_ANA_LSB+:4]; // (RL9)

      // Driver states; only the first two channels honour the state fields
      for (genvar d = 0; d < 2; d++)
      begin : g_drv
        logic [1:0] pol;
        assign pol = (c < 2) ? cfg_q[c][som_pkg::CFG_POLA_LSB+2*d+:2] : som_pkg::POL_NORMAL;
        always_ff @(posedge i_clk)
        begin
          if (!i_rst_n)
          begin
            o_drv[2*c+d] <= 1'b0;
            o_drv_oe[2*c+d] <= 1'b0;
          end
          else
          begin
            o_drv_oe[2*c+d] <= drv_en[d] && pol != som_pkg::POL_HIZ; // (RL10)
            if (pol == som_pkg::POL_NORMAL)
              o_drv[2*c+d] <= drv_en[d] && gclk[c];
            else if (pol == som_pkg::POL_INVERT)
              o_drv[2*c+d] <= drv_en[d] && !gclk[c];
            else
              o_drv[2*c+d] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin replicas: the lowest-numbered enabled source wins
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_pin
      logic act, lvl;
      always_comb
      begin
        act = 1'b0;
        lvl = 1'b0;
        for (int c = NCH - 1; c >= 0; c--)
          if (HAS_SR[c] && cfg_q[c][som_pkg::CFG_SR_SEL] && cfg_q[c][som_pkg::CFG_REP_EN]
              && cfg_q[c][som_pkg::CFG_REP_PIN] == 1'(g))
          begin
            act = 1'b1;
            lvl = rep[c]; // (RL6)
          end
      end
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
        begin
          o_pin[g] <= 1'b0;
          o_pin_oe[g] <= 1'b0;
        end
        else
        begin
          o_pin_oe[g] <= pin_ctrl_q[g];
          o_pin[g] <= pin_ctrl_q[g] && act && lvl; // (RL5)
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Events: loss of analog or digital lock, and any channel entering mute
  assign ev = {|(muted & ~muted_prev_q),
               filt_prev_q[2*NPLL-1:NPLL] & ~dlock,
               filt_prev_q[NPLL-1:0] & ~alock};

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      muted_prev_q <= '1;
    else
      muted_prev_q <= muted;
  end

  // Register writes; a new event wins over a write-one clear
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_q <= som_pkg::CTRL_RST;
      int_stat_q <= '0;
      int_mask_q <= '0;
      mute_ctrl_q <= som_pkg::MUTE_CTRL_RST;
      pin_ctrl_q <= '0;
      req_ctrl_q <= '0;
      soft_rst_q <= 1'b0;
      for (int c = 0; c < NCH; c++)
      begin
        cfg_q[c] <= som_pkg::CH_CFG_RST;
        srdiv_q[c] <= som_pkg::CH_SRDIV_RST;
        dly_q[c] <= '0;
      end
    end
    else
    begin
      soft_rst_q <= i_wr && i_addr == som_pkg::ADDR_CTRL && i_wdata[som_pkg::CTRL_SOFT_RST];
      int_stat_q <= (int_stat_q & ~((i_wr && i_addr == som_pkg::ADDR_INT_STAT)
                    ? i_wdata : 32'h0)) | 32'(ev);
      if (i_wr)
      begin
        case (i_addr)
          som_pkg::ADDR_CTRL: ctrl_q <= {30'h0, i_wdata[1], 1'b0};
          som_pkg::ADDR_INT_MASK: int_mask_q <= 32'(i_wdata[NEV-1:0]);
          som_pkg::ADDR_MUTE_CTRL: mute_ctrl_q <= 32'(i_wdata[3*NPLL-1:0]);
          som_pkg::ADDR_PIN_CTRL: pin_ctrl_q <= 32'(i_wdata[1:0]);
          som_pkg::ADDR_SR_REQ_CTRL: req_ctrl_q <= i_wdata[7:0]; // (RL3) (RL4)
          default:
          begin
            for (int c = 0; c < NCH; c++)
            begin
              if (i_addr == som_pkg::ADDR_CH_CFG + 8'(c))
                cfg_q[c] <= {7'h0, i_wdata[24:0]};
              if (i_addr == som_pkg::ADDR_CH_SRDIV + 8'(c))
                srdiv_q[c] <= {12'h0, i_wdata[19:0]};
              if (i_addr == som_pkg::ADDR_CH_DLY + 8'(c))
                dly_q[c] <= {16'h0, i_wdata[15:0]};
            end
          end
        endcase
      end
    end
  end

  // Read mux; unmapped indices read zero
  always_comb
  begin
    rdata_d = 32'h0;
    case (i_addr)
      som_pkg::ADDR_CTRL: rdata_d = ctrl_q;
      som_pkg::ADDR_STATUS: rdata_d = {5'h0, started_q, muted, phlock, dlock, alock};
      som_pkg::ADDR_INT_STAT: rdata_d = int_stat_q;
      som_pkg::ADDR_INT_MASK: rdata_d = int_mask_q;
      som_pkg::ADDR_MUTE_CTRL: rdata_d = mute_ctrl_q;
      som_pkg::ADDR_PIN_CTRL: rdata_d = pin_ctrl_q;
      som_pkg::ADDR_SR_REQ_CTRL: rdata_d = {24'h0, req_ctrl_q};
      default:
      begin
        for (int c = 0; c < NCH; c++)
        begin
          if (i_addr == som_pkg::ADDR_CH_CFG + 8'(c))
            rdata_d = cfg_q[c];
          if (i_addr == som_pkg::ADDR_CH_SRDIV + 8'(c))
            rdata_d = srdiv_q[c];
          if (i_addr == som_pkg::ADDR_CH_DLY + 8'(c))
            rdata_d = dly_q[c];
        end
      end
    endcase
  end

  // Read data one cycle after the strobe; interrupt is a registered level
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 32'h0;
      o_irq <= 1'b0;
    end
    else
    begin
      o_rdata <= i_rd ? rdata_d : 32'h0;
      o_irq <= |(int_stat_q & int_mask_q);
    end
  end
endmodule

//--- tb/som_top_assertions.sv
/*
  Port checker for som_top: read slot, pin gating, interrupt mask,
  mute of channel 0 on digital unlock and glitch-free high widths on channel 0.
  Assumes source ticks come no closer than every second cycle.
*/
`timescale 1ns/10ps
module som_top_assertions #(
  parameter int NCH = 9,
  parameter int NPLL = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Lock status and outputs
  input wire logic [NPLL-1:0] i_dpll_lock,
  input wire logic [2*NCH-1:0] o_drv,
  input wire logic [2*NCH-1:0] o_drv_oe,
  input wire logic [1:0] o_pin,
  input wire logic [1:0] o_pin_oe,
  input wire logic o_irq
);
  logic [31:0] cfg0_q;
  logic sel_q;
  logic [5:0] low_q;
  ////////////////////////////////////////
  // Shadows of channel 0 config and loop 0 digital mute select
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cfg0_q <= som_pkg::CH_CFG_RST;
      sel_q <= som_pkg::MUTE_CTRL_RST[3];
    end
    else if (i_wr && i_addr == som_pkg::ADDR_CH_CFG)
      cfg0_q <= i_wdata;
    else if (i_wr && i_addr == som_pkg::ADDR_MUTE_CTRL)
      sel_q <= i_wdata[3];
  end
  // Unlock age; any write restarts it
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || i_dpll_lock[0] || i_wr)
      low_q <= 6'h00;
    else if (low_q != 6'h3F)
      low_q <= low_q + 6'h01;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_mask_wr;
    i_wr && i_addr == som_pkg::ADDR_INT_MASK;
  endsequence
  sequence s_mask_rd;
    i_rd && i_addr == som_pkg::ADDR_INT_MASK;
  endsequence
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data seen outside its slot");
  a_mask_readback: assert property (s_mask_wr ##2 s_mask_rd |=>
    o_rdata[6:0] == $past(i_wdata[6:0], 3))
    else $error("mask read back differs");
  a_bad_index: assert property (i_rd && i_addr == 8'h0F |=> o_rdata == 32'h0)
    else $error("unmapped index read not zero");
  a_pin_needs_oe: assert property ((o_pin & ~o_pin_oe) == 2'h0)
    else $error("pin replica without pin enable");
  a_irq_masked: assert property (s_mask_wr and i_wdata[6:0] == 7'h00 |-> ##2 !o_irq)
    else $error("interrupt high with all sources masked");
  a_mute_on_unlock: assert property (cfg0_q[som_pkg::CFG_MUTE_EN] && sel_q &&
    cfg0_q[18:17] == 2'h0 && low_q >= 6'h28 |-> !o_drv[0])
    else $error("channel 0 not muted on unlock");
  a_high_width: assert property ($rose(o_drv[0]) |=> o_drv[0])
    else $error("shortened high pulse on channel 0");
  a_hiz_off: assert property (i_wr && i_addr == som_pkg::ADDR_CH_CFG + 8'h01 &&
    i_wdata[22:21] == som_pkg::POL_HIZ |-> ##[1:4] !o_drv_oe[2])
    else $error("hi-z state still driving");
endmodule
bind som_top som_top_assertions #(.NCH(NCH), .NPLL(NPLL)) i_som_top_assertions (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_dpll_lock(i_dpll_lock),
  .o_drv(o_drv), .o_drv_oe(o_drv_oe), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
  .o_irq(o_irq)
);

//--- tb/som_rx_model.sv
/*
  Downstream receiver model: counts rising edges and the cycles
  between them. Assumes the line is sampled on the system clock.
*/
`timescale 1ns/10ps
module som_rx_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Received line
  input wire logic i_line,
  // Edge count and last period
  output int o_rises,
  output int o_period
);
  int age;
  logic last;
  // Only rises are counted; a receiver latches on its rising edge
  always @(posedge i_clk)
  begin
    age <= age + 1;
    last <= i_line;
    if (!i_rst_n)
    begin
      o_rises <= 0;
      age <= 0;
    end
    else if (i_line && !last)
    begin
      o_rises <= o_rises + 1;
      o_period <= age;
      age <= 1;
    end
  end
endmodule

//--- tb/testbench.sv
/*
  Testbench for som_top: registers, start-up, cascade, mute, irq,
  output states and pin replica.
  Assumes all loops tick together every second cycle.
*/
`timescale 1ns/10ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [2:0] i_src_tick = 3'h0;
  logic [2:0] i_apll_lock = 3'h0;
  logic [2:0] i_dpll_lock = 3'h7;
  logic [31:0] o_rdata;
  logic [17:0] o_drv;
  logic [17:0] o_drv_oe;
  logic [1:0] o_pin;
  logic [1:0] o_pin_oe;
  logic o_irq;
  int rises [4];
  int per [4];
  int num_errors = 0;
  int num_checks = 0;
  int r0;
  int r2;
  logic [3:0] rx_line;
  ////////////////////////////////////////
  // Free-running clock and source ticks every other cycle
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) i_src_tick <= {3{~i_src_tick[0]}};
  som_top i_som_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_src_tick(i_src_tick), .i_apll_lock(i_apll_lock), .i_dpll_lock(i_dpll_lock),
    .i_dpll_phlock(3'h7), .i_sysref_req(1'b0), .o_drv(o_drv), .o_drv_oe(o_drv_oe),
    .o_analog_dly(), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_irq(o_irq));
  // Receivers on channels 0, 2, 4 and pin 0
  assign rx_line = {o_pin[0], o_drv[8], o_drv[4], o_drv[0]};
  for (genvar k = 0; k < 4; k++)
  begin : g_rx
    som_rx_model i_som_rx_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_line(rx_line[k]), .o_rises(rises[k]), .o_period(per[k]));
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Writes leave one idle edge; return just past it so outputs are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk) #1;
  endtask
  // Read data stand only in the cycle after the strobe: sample mid-cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata & m, e);
    @(posedge i_clk);
  endtask
  task automatic wait_pin_or_drv(input int b);
    int n;
    n = 0;
    while ((({o_pin, o_drv} >> b) & 20'h1) !== 20'h1 && n < 400)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n == 400)
    begin
      num_errors++;
      $display("unexpected timeout at %0t", $time);
      close_out();
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    idle(8);
    i_rst_n <= 1'b1;
    rd(som_pkg::ADDR_CTRL, 32'hFFFF_FFFF, som_pkg::CTRL_RST);
    rd(som_pkg::ADDR_MUTE_CTRL, 32'hFFFF_FFFF, som_pkg::MUTE_CTRL_RST);
    rd(som_pkg::ADDR_CH_CFG, 32'hFFFF_FFFF, som_pkg::CH_CFG_RST);
    rd(som_pkg::ADDR_CH_SRDIV, 32'hFFFF_FFFF, som_pkg::CH_SRDIV_RST);
    rd(8'h0F, 32'hFFFF_FFFF, 32'h0);
    wr(som_pkg::ADDR_INT_MASK, 32'h0000_007F);
    rd(som_pkg::ADDR_INT_MASK, 32'hFFFF_FFFF, 32'h0000_007F);
    wr(som_pkg::ADDR_SR_REQ_CTRL, 32'h0000_0034);
    rd(som_pkg::ADDR_SR_REQ_CTRL, 32'h0000_003F, 32'h0000_0034);
    chk({14'h0, o_drv}, 32'h0);
    $display("test registers done");
    i_apll_lock <= 3'h7;
    wait_pin_or_drv(0);
    wr(som_pkg::ADDR_CH_SRDIV + 8'h04, 32'h0000_0002);
    wr(som_pkg::ADDR_CH_CFG + 8'h04, som_pkg::CH_CFG_RST | 32'h1000);
    wr(som_pkg::ADDR_CH_CFG + 8'h02, som_pkg::CH_CFG_RST | 32'h1000);
    idle(150);
    chk(per[0], 8);
    chk(per[1], 8);
    chk(per[2], 16);
    $display("test start and cascade done");
    wr(som_pkg::ADDR_CH_CFG, som_pkg::CH_CFG_RST | 32'h4000);
    i_dpll_lock <= 3'h6;
    idle(60);
    r0 = rises[0];
    idle(40);
    chk(rises[0] - r0, 5);
    wr(som_pkg::ADDR_MUTE_CTRL, 32'h0000_0008);
    idle(60);
    r0 = rises[0];
    r2 = rises[1];
    idle(40);
    chk(rises[0] - r0, 0);
    chk(rises[1] - r2, 5);
    rd(som_pkg::ADDR_STATUS, 32'h0000_0200, 32'h0000_0200);
    rd(som_pkg::ADDR_INT_STAT, 32'h0000_0048, 32'h0000_0048);
    chk({31'h0, o_irq}, 32'h1);
    wr(som_pkg::ADDR_INT_MASK, 32'h0);
    chk({31'h0, o_irq}, 32'h0);
    wr(som_pkg::ADDR_INT_MASK, 32'h0000_007F);
    i_dpll_lock <= 3'h7;
    wait_pin_or_drv(0);
    wr(som_pkg::ADDR_INT_STAT, 32'h0000_007F);
    rd(som_pkg::ADDR_INT_STAT, 32'h0000_007F, 32'h0);
    chk({31'h0, o_irq}, 32'h0);
    $display("test mute and interrupt done");
    wr(som_pkg::ADDR_CH_CFG + 8'h01, som_pkg::CH_CFG_RST | 32'h01C0_0000);
    idle(4);
    chk({14'h0, o_drv_oe} & 32'hC, 32'h8);
    repeat (16)
    begin
      @(posedge i_clk);
      chk({31'h0, o_drv[3]}, 32'h0);
    end
    wr(som_pkg::ADDR_CH_CFG + 8'h01, som_pkg::CH_CFG_RST | 32'h0020_0000);
    idle(4);
    repeat (16)
    begin
      @(posedge i_clk);
      chk({31'h0, o_drv[2] ^ o_drv[3]}, 32'h1);
    end
    $display("test single-ended states done");
    wr(som_pkg::ADDR_CH_CFG + 8'h01, som_pkg::CH_CFG_RST | 32'h0009_B000);
    wr(som_pkg::ADDR_CH_CFG + 8'h04, som_pkg::CH_CFG_RST | 32'h0009_9000);
    idle(100);
    chk(rises[3], 0);
    wr(som_pkg::ADDR_PIN_CTRL, 32'h0000_0001);
    wait_pin_or_drv(18);
    idle(100);
    chk(per[3], 32);
    chk({30'h0, o_pin_oe}, 32'h1);
    $display("test pin replica done");
    close_out();
  end
endmodule
